// ==== hdl/oqcl_top.sv ====
`timescale 1ns/1ps
module oqcl_top #(
  parameter int NPORTS = oqcl_pkg::OQCL_PORTS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [oqcl_pkg::OQCL_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmit queues, one lane per port
  input wire logic [NPORTS-1:0] pkt_arrive,
  input wire logic [4*NPORTS-1:0] occupancy,
  // leak pulses to the receive counters
  output logic [NPORTS-1:0] rx_leak_pulse,
  // interrupt
  output logic irq
);
  import oqcl_pkg::*;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (NPORTS < 1 || NPORTS > OQCL_PORTS) begin : g_bad_ports
    $error("NPORTS must lie between 1 and 16");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic pready_q, pslverr_q, irq_q, ref_sel_q, base_tick_q, seen_q;
  logic [31:0] prdata_q, rdata;
  logic access, done, wr;
  logic hit_status, hit_thresh, hit_istat, hit_imask, hit_ctrl, mapped;
  logic [3:0] port_idx;
  logic [19:0] port_base;
  logic [21:0] acc_q, acc_sum, unit_ps;
  logic [15:0] istat_q, istat_d, imask_q, clr_vec, hit_ev, hit_vec;
  logic [15:0] hit_prev_q;
  logic [NPORTS-1:0] leak_vec, rx_leak_q, wr_st_vec, wr_th_vec;
  logic [31:0] status_words [NPORTS];
  logic [31:0] thresh_words [NPORTS];
  logic [7:0] gap_q;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // port index sits in address bits 11:8
  assign access = psel && penable;
  assign done = access && pready_q;
  assign port_idx = paddr[11:8];
  assign port_base = paddr & ~OQCL_PORT_MASK;
  assign hit_status = port_base == OQCL_STATUS_BASE
                      && 32'(port_idx) < NPORTS;
  assign hit_thresh = port_base == OQCL_THRESH_BASE
                      && 32'(port_idx) < NPORTS;
  assign hit_istat = paddr == OQCL_ISTAT_ADDR;
  assign hit_imask = paddr == OQCL_IMASK_ADDR;
  assign hit_ctrl = paddr == OQCL_CTRL_ADDR;
  assign mapped = hit_status || hit_thresh || hit_istat || hit_imask
                  || hit_ctrl;
  assign wr = done && pwrite && mapped;

  // read data mux
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_status) begin
      rdata = status_words[port_idx];
    end else if (hit_thresh) begin
      rdata = thresh_words[port_idx];
    end else if (hit_istat) begin
      rdata = {16'h0000, istat_q};
    end else if (hit_imask) begin
      rdata = {16'h0000, imask_q};
    end else if (hit_ctrl) begin
      rdata = {31'h0000_0000, ref_sel_q};
    end
  end

  // ----------------------------------------------------------------
  // apb response
  // ----------------------------------------------------------------
  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= access && !pready_q;
    end
  end

  // read data and error captured with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (access && !pready_q) begin
      prdata_q <= (mapped && !pwrite) ? rdata : 32'h0000_0000;
      pslverr_q <= !mapped;
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // reference select and base unit tick
  // ----------------------------------------------------------------
  // ref select: 0 for 125 MHz unit, 1 for 156.25 MHz unit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_sel_q <= 1'b0;
    end else if (wr && hit_ctrl) begin
      ref_sel_q <= pwdata[OQCL_REFSEL_BIT];
    end
  end

  // fractional accumulator keeps the average unit exact
  assign unit_ps = ref_sel_q ? OQCL_UNIT_156_PS : OQCL_UNIT_125_PS;
  assign acc_sum = acc_q + OQCL_CLK_PERIOD_PS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 22'h00_0000;
      base_tick_q <= 1'b0;
    end else if (wr && hit_ctrl) begin
      acc_q <= 22'h00_0000;
      base_tick_q <= 1'b0;
    end else if (acc_sum >= unit_ps) begin
      acc_q <= acc_sum - unit_ps;
      base_tick_q <= 1'b1;
    end else begin
      acc_q <= acc_sum;
      base_tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // per port monitors
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    assign wr_st_vec[p] = wr && hit_status && 32'(port_idx) == p;
    assign wr_th_vec[p] = wr && hit_thresh && 32'(port_idx) == p;

    oqcl_port u_port (
      .pclk(pclk),
      .presetn(presetn),
      .base_tick(base_tick_q),
      .pkt_arrive(pkt_arrive[p]),
      .occupancy(occupancy[4*p +: 4]),
      .wr_status(wr_st_vec[p]),
      .wr_thresh(wr_th_vec[p]),
      .clr_count(clr_vec[p]),
      .wdata(pwdata),
      .status_word(status_words[p]),
      .thresh_word(thresh_words[p]),
      .limit_hit(hit_vec[p]),
      .leak_pulse(leak_vec[p])
    );
  end

  // unused port lanes read as idle
  if (NPORTS < OQCL_PORTS) begin : g_fill
    assign hit_vec[OQCL_PORTS-1:NPORTS] = '0;
  end

  // ----------------------------------------------------------------
  // receive side leak
  // ----------------------------------------------------------------
  // same expiry that leaks the transmit count goes out to the receiver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_leak_q <= '0;
    end else begin
      rx_leak_q <= leak_vec;
    end
  end

  assign rx_leak_pulse = rx_leak_q;

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // writing one clears the flag and the port's count
  assign clr_vec = (wr && hit_istat) ? pwdata[15:0] : 16'h0000;
  assign hit_ev = hit_vec & ~hit_prev_q;
  // a new hit in the clearing cycle keeps the flag set
  assign istat_d = (istat_q & ~clr_vec) | hit_ev;

  // limit edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_prev_q <= 16'h0000;
    end else begin
      hit_prev_q <= hit_vec;
    end
  end

  // sticky status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= 16'h0000;
    end else begin
      istat_q <= istat_d;
    end
  end

  // mask register, one enables the port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_q <= OQCL_IMASK_RST;
    end else if (wr && hit_imask) begin
      imask_q <= pwdata[15:0];
    end
  end

  // level interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(istat_q & imask_q);
    end
  end

  assign irq = irq_q;

  // ----------------------------------------------------------------
  // check helpers
  // ----------------------------------------------------------------
  // cycles since the previous base tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 8'h00;
      seen_q <= 1'b0;
    end else if (wr && hit_ctrl) begin
      gap_q <= 8'h00;
      seen_q <= 1'b0;
    end else if (base_tick_q) begin
      gap_q <= 8'h01;
      seen_q <= 1'b1;
    end else if (gap_q != 8'hff) begin
      gap_q <= gap_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // base ticks keep the unit of the selected reference
  base_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    base_tick_q && seen_q && !$past(wr && hit_ctrl)
    |-> (ref_sel_q ? (gap_q == 8'd163 || gap_q == 8'd164)
                   : (gap_q == 8'd204 || gap_q == 8'd205)))
    else $error("base unit tick spacing wrong");
  // a base tick lasts one cycle only
  tick_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    base_tick_q |=> !base_tick_q)
    else $error("base unit tick longer than one cycle");

  // a new limit hit sets the flag of port 0
  flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    hit_vec[0] && !hit_prev_q[0] |=> istat_q[0])
    else $error("limit hit did not set flag");
  // a masked-in flag holds the interrupt up
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    (istat_q[0] && imask_q[0]) [*2] |-> irq_q)
    else $error("unmasked flag without interrupt");
  // no interrupt without an unmasked flag
  irq_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(istat_q & imask_q) == 16'h0000 |-> !irq_q)
    else $error("interrupt without unmasked flag");
  // a one written to the flag clears flag and count together
  flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_istat && pwdata[0] && !hit_ev[0]
    |=> !istat_q[0] && status_words[0][31:16] == 16'h0000)
    else $error("flag write did not clear flag and count");
  // each transmit leak goes out to the receiver once
  rx_leak_a: assert property (@(posedge pclk) disable iff (!presetn)
    leak_vec[0] |=> rx_leak_pulse[0] ##1 !rx_leak_pulse[0])
    else $error("receive leak pulse missing");

  // one wait state on every access
  apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pready_q |=> pready_q ##1 !pready_q)
    else $error("apb answer not after one wait");
  // unmapped addresses answer with an error
  apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pready_q && !mapped |=> pslverr_q)
    else $error("unmapped access not refused");
  // a refused access returns zero data
  rd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pready_q && !mapped
    |=> prdata_q == 32'h0000_0000)
    else $error("refused access returned data");
  // an access writes at most one port register
  decode_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0({wr_st_vec, wr_th_vec}))
    else $error("one access wrote several registers");

  // ----------------------------------------------------------------
  // per port flag, count and leak checks
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NPORTS; c++) begin : g_chk
    // a flag stays up until software writes a one to it
    flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      istat_q[c] && !clr_vec[c] |=> istat_q[c])
      else $error("flag dropped without a clear");

    // a flag only rises on a new limit hit
    flag_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
      !istat_q[c] && !hit_ev[c] |=> !istat_q[c])
      else $error("flag rose without a limit hit");

    // the flag write empties the count on the next edge
    count_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      clr_vec[c] |=> status_words[c][31:16] == 16'h0000)
      else $error("flag write left the count");

    // the receive leak trails the transmit leak by one cycle
    rx_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      rx_leak_q[c] == $past(leak_vec[c]))
      else $error("receive leak out of step");
  end

  // main scenarios
  irq_rise_c: cover property (@(posedge pclk) disable iff (!presetn)
    !irq_q ##1 irq_q);
  leak_c: cover property (@(posedge pclk) disable iff (!presetn)
    leak_vec[0] && status_words[0][31:16] != 16'h0000);
  sat_c: cover property (@(posedge pclk) disable iff (!presetn)
    status_words[0][31:16] == 16'hffff);
  clear_c: cover property (@(posedge pclk) disable iff (!presetn)
    wr && hit_istat && pwdata[0] && istat_q[0]);
  fast_ref_c: cover property (@(posedge pclk) disable iff (!presetn)
    base_tick_q && ref_sel_q);

endmodule : oqcl_top

// ==== hdl/oqcl_pkg.sv ====
package oqcl_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int OQCL_PORTS = 16;
  localparam int OQCL_AW = 20;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [19:0] OQCL_STATUS_BASE = 20'h13084;
  localparam logic [19:0] OQCL_THRESH_BASE = 20'h13080;
  localparam logic [19:0] OQCL_PORT_MASK = 20'h00f00;
  localparam logic [19:0] OQCL_ISTAT_ADDR = 20'h14000;
  localparam logic [19:0] OQCL_IMASK_ADDR = 20'h14004;
  localparam logic [19:0] OQCL_CTRL_ADDR = 20'h14008;

  // ----------------------------------------------------------------
  // field positions (bit 0 of the word is its lsb)
  // ----------------------------------------------------------------
  localparam int OQCL_CNT_LSB = 16;
  localparam int OQCL_CNT_MSB = 31;
  localparam int OQCL_LIM_LSB = 0;
  localparam int OQCL_LIM_MSB = 15;
  localparam int OQCL_DEPTH_LSB = 12;
  localparam int OQCL_DEPTH_MSB = 15;
  localparam int OQCL_MODE_BIT = 11;
  localparam int OQCL_LEAK_LSB = 0;
  localparam int OQCL_LEAK_MSB = 10;
  localparam int OQCL_REFSEL_BIT = 0;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [15:0] OQCL_CNT_RST = 16'h0000;
  localparam logic [15:0] OQCL_CNT_MAX = 16'hffff;
  localparam logic [15:0] OQCL_LIM_RST = 16'h0000;
  localparam logic [3:0] OQCL_DEPTH_RST = 4'h0;
  localparam logic [10:0] OQCL_LEAK_RST = 11'h000;
  localparam logic [15:0] OQCL_IMASK_RST = 16'h0000;
  localparam logic [3:0] OQCL_DEPTH_MIN = 4'h1;
  localparam logic [3:0] OQCL_DEPTH_MAX = 4'h7;

  // ----------------------------------------------------------------
  // timing: base leak unit in ps, accumulated per pclk period
  // ----------------------------------------------------------------
  localparam logic [21:0] OQCL_CLK_PERIOD_PS = 22'd10000;
  localparam logic [21:0] OQCL_UNIT_125_PS = 22'd2048000;
  localparam logic [21:0] OQCL_UNIT_156_PS = 22'd1638400;

endpackage : oqcl_pkg

// ==== hdl/oqcl_port.sv ====
`timescale 1ns/1ps
module oqcl_port (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // shared base unit tick
  input wire logic base_tick,
  // queue side
  input wire logic pkt_arrive,
  input wire logic [3:0] occupancy,
  // register access
  input wire logic wr_status,
  input wire logic wr_thresh,
  input wire logic clr_count,
  input wire logic [31:0] wdata,
  // state
  output logic [31:0] status_word,
  output logic [31:0] thresh_word,
  output logic limit_hit,
  output logic leak_pulse
);
  import oqcl_pkg::*;

  logic [15:0] count_q, count_d, limit_q, wdata_cnt;
  logic [3:0] depth_q;
  logic mode_q, congested, inc, dec, leak_pulse_q;
  logic [10:0] leak_q, leak_cnt_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  assign wdata_cnt = wdata[OQCL_CNT_MSB:OQCL_CNT_LSB];

  // limit field of the status word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_q <= OQCL_LIM_RST;
    end else if (wr_status) begin
      limit_q <= wdata[OQCL_LIM_MSB:OQCL_LIM_LSB];
    end
  end

  // level, mode and leak interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_q <= OQCL_DEPTH_RST;
      mode_q <= 1'b0;
      leak_q <= OQCL_LEAK_RST;
    end else if (wr_thresh) begin
      depth_q <= wdata[OQCL_DEPTH_MSB:OQCL_DEPTH_LSB];
      mode_q <= wdata[OQCL_MODE_BIT];
      leak_q <= wdata[OQCL_LEAK_MSB:OQCL_LEAK_LSB];
    end
  end

  // ----------------------------------------------------------------
  // leak timer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      leak_cnt_q <= 11'h000;
      leak_pulse_q <= 1'b0;
    end else if (wr_thresh || leak_q == 11'h000) begin
      leak_cnt_q <= 11'h000;
      leak_pulse_q <= 1'b0;
    end else if (base_tick) begin
      if (leak_cnt_q == leak_q - 11'h001) begin
        leak_cnt_q <= 11'h000;
        leak_pulse_q <= 1'b1;
      end else begin
        leak_cnt_q <= leak_cnt_q + 11'h001;
        leak_pulse_q <= 1'b0;
      end
    end else begin
      leak_pulse_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // congestion counter
  // ----------------------------------------------------------------
  // level code n asks for n+1 packets, reserved codes never count
  assign congested = depth_q >= OQCL_DEPTH_MIN && depth_q <= OQCL_DEPTH_MAX
                     && occupancy >= depth_q + 4'h1;
  assign inc = pkt_arrive && congested && limit_q != 16'h0000;
  assign dec = leak_pulse_q && limit_q != 16'h0000
               && count_q != 16'h0000;

  // clear beats load beats counting; saturated value holds
  always_comb begin
    count_d = count_q;
    if (clr_count) begin
      count_d = OQCL_CNT_RST;
    end else if (wr_status) begin
      count_d = wdata_cnt;
    end else if (count_q == OQCL_CNT_MAX) begin
      count_d = count_q;
    end else if (inc && !dec) begin
      count_d = count_q + 16'h0001;
    end else if (dec && !inc) begin
      count_d = count_q - 16'h0001;
    end
  end

  // counter register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= OQCL_CNT_RST;
    end else begin
      count_q <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign status_word = {count_q, limit_q};
  assign thresh_word = {16'h0000, depth_q, mode_q, leak_q};
  assign limit_hit = limit_q != 16'h0000 && count_q >= limit_q;
  assign leak_pulse = leak_pulse_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  clear_zero_a: assert property (clr_count |=> count_q == 16'h0000)
    else $error("count not cleared by flag write");
  sw_load_a: assert property (wr_status && !clr_count
    |=> count_q == $past(wdata_cnt))
    else $error("count not loaded by write");
  sat_hold_a: assert property (count_q == 16'hffff && !clr_count
    && !wr_status |=> count_q == 16'hffff)
    else $error("saturated count moved");
  zero_floor_a: assert property (count_q == 16'h0000 && !wr_status
    && !inc |=> count_q == 16'h0000)
    else $error("count went below zero");
  inc_step_a: assert property (inc && !dec && !clr_count && !wr_status
    && count_q != 16'hffff |=> count_q == $past(count_q) + 16'h0001)
    else $error("congested arrival did not count");
  limit_off_a: assert property (limit_q == 16'h0000 && !clr_count
    && !wr_status |=> $stable(count_q))
    else $error("count moved with zero limit");
  leak_off_a: assert property (leak_q == 11'h000 |=> !leak_pulse_q)
    else $error("leak with zero interval");
  leak_restart_a: assert property (wr_thresh
    |=> leak_cnt_q == 11'h000 && !leak_pulse_q)
    else $error("leak timer not restarted");

endmodule : oqcl_port

// ==== verif/oqcl_top_tb.sv ====
`timescale 1ns/1ps
module oqcl_top_tb;
  import oqcl_pkg::*;
  logic pclk;
  logic presetn;
  logic [19:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] pkt_arrive;
  logic [63:0] occupancy;
  logic [15:0] rx_leak_pulse;
  logic irq;
  logic [31:0] rd;
  logic err;
  int mismatches;
  int checks;
  int n;
  oqcl_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pkt_arrive(pkt_arrive), .occupancy(occupancy),
    .rx_leak_pulse(rx_leak_pulse), .irq(irq));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [19:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      mismatches++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic arrive(input int times);
    repeat (times) begin
      @(posedge pclk);
      pkt_arrive[0] <= 1'b1;
      @(posedge pclk);
      pkt_arrive[0] <= 1'b0;
    end
  endtask : arrive
  // cycles until the next leak pulse of port 0
  task automatic wait_leak(output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (rx_leak_pulse[0] !== 1'b1 && c < 600);
    if (c >= 600) begin
      mismatches++;
      give_verdict();
    end
  endtask : wait_leak
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_map();
    apb(0, OQCL_STATUS_BASE, 0); chk(rd, 0);
    apb(0, OQCL_STATUS_BASE + 20'h00f00, 0); chk(rd, 0);
    apb(1, OQCL_STATUS_BASE + 20'h00100, 32'h1234_5678);
    apb(0, OQCL_STATUS_BASE + 20'h00100, 0); chk(rd, 32'h1234_5678);
    apb(0, OQCL_STATUS_BASE, 0); chk(rd, 0);
    apb(0, 20'h13000, 0); chk({31'h0, err}, 1);
  endtask : t_reset_map
  task automatic t_count_flag();
    apb(1, OQCL_IMASK_ADDR, 32'h1);
    apb(1, OQCL_THRESH_BASE, 32'h0000_2000); // three or more
    apb(1, OQCL_STATUS_BASE, 32'h0000_0003);
    occupancy[3:0] <= 4'h2;
    arrive(2);
    apb(0, OQCL_STATUS_BASE, 0); chk(rd, 32'h0000_0003);
    occupancy[3:0] <= 4'h3;
    arrive(2);
    apb(0, OQCL_STATUS_BASE, 0); chk(rd, 32'h0002_0003);
    chk({31'h0, irq}, 0);
    arrive(1);
    apb(0, OQCL_ISTAT_ADDR, 0); chk(rd, 32'h1);
    chk({31'h0, irq}, 1);
    apb(1, OQCL_IMASK_ADDR, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 0);
    apb(1, OQCL_ISTAT_ADDR, 32'h1);
    apb(0, OQCL_STATUS_BASE, 0); chk(rd, 32'h0000_0003);
    apb(0, OQCL_ISTAT_ADDR, 0); chk(rd, 0);
    apb(1, OQCL_THRESH_BASE, 32'h0000_0000); // code 0 reserved
    arrive(1);
    apb(0, OQCL_STATUS_BASE, 0); chk(rd, 32'h0000_0003);
    apb(1, OQCL_THRESH_BASE, 32'h0000_1000);
    apb(1, OQCL_STATUS_BASE, 32'hfffe_0000);
    arrive(1);
    apb(0, OQCL_STATUS_BASE, 0); chk(rd, 32'hfffe_0000);
    apb(1, OQCL_STATUS_BASE, 32'hfffe_ffff);
    arrive(3);
    apb(0, OQCL_STATUS_BASE, 0); chk(rd, 32'hffff_ffff);
    apb(1, OQCL_ISTAT_ADDR, 32'h1);
    occupancy[3:0] <= 4'h0;
  endtask : t_count_flag
  task automatic t_leak();
    apb(1, OQCL_STATUS_BASE, 32'h0005_0010);
    repeat (300) @(posedge pclk);
    chk({31'h0, rx_leak_pulse[0]}, 0);
    apb(0, OQCL_STATUS_BASE, 0); chk(rd, 32'h0005_0010);
    apb(1, OQCL_STATUS_BASE, 32'h0002_0010);
    apb(1, OQCL_THRESH_BASE, 32'h0000_1001);
    apb(0, OQCL_THRESH_BASE, 0); chk(rd, 32'h0000_1001);
    wait_leak(n);
    apb(0, OQCL_STATUS_BASE, 0); chk(rd, 32'h0001_0010);
    wait_leak(n);
    wait_leak(n);
    chk({31'h0, n >= 204 && n <= 205}, 1);
    apb(0, OQCL_STATUS_BASE, 0); chk(rd, 32'h0000_0010);
    apb(1, OQCL_CTRL_ADDR, 32'h1);
    apb(1, OQCL_THRESH_BASE, 32'h0000_1002);
    wait_leak(n);
    wait_leak(n);
    chk({31'h0, n >= 327 && n <= 328}, 1);
  endtask : t_leak
  // ----------------------------------------------------------------
  // clock, reset and main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    paddr = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = '0;
    pkt_arrive = '0;
    occupancy = '0;
    mismatches = 0;
    checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_count_flag();
    t_leak();
    give_verdict();
  end
endmodule : oqcl_top_tb
